// >>> shared/pcsr_cfg.svh
// register offsets, field positions, reset values for the pad config and soft reset bank
`ifndef PCSR_CFG_SVH
`define PCSR_CFG_SVH
`define PCSR_ADDR_PAD_A 16'hf7a1
`define PCSR_ADDR_PAD_B 16'hf7a2
`define PCSR_ADDR_CLK_PAD 16'hf7a3
`define PCSR_ADDR_SOFT_RST 16'hf890
`define PCSR_ADDR_SYNTH_LO 16'hf000
`define PCSR_ADDR_SYNTH_HI 16'hf006
`define PCSR_PULL_BIT 4
`define PCSR_SLEW_HI 3
`define PCSR_SLEW_LO 2
`define PCSR_DRIVE_HI 1
`define PCSR_DRIVE_LO 0
`define PCSR_PAD_MASK 16'h001f
`define PCSR_SOFT_MASK 16'h0001
`define PCSR_RST_PAD_A 16'h0018
`define PCSR_RST_PAD_B 16'h0018
`define PCSR_RST_CLK_PAD 16'h0008
`define PCSR_RST_SOFT 16'h0001
`define PCSR_RST_SOFT_BIT 1'b1
`endif

// >>> shared/pcsr_pkg.sv
// types shared by the pad config and soft reset bank
package pcsr_pkg;
  typedef logic [15:0] pcsr_word_t;
  typedef logic [15:0] pcsr_addr_t;
  typedef enum logic [1:0] {
    PCSR_SLEW_SLOWEST,
    PCSR_SLEW_SLOW,
    PCSR_SLEW_FAST,
    PCSR_SLEW_FASTEST
  } pcsr_slew_e;
endpackage : pcsr_pkg

// >>> logic/pcsr_pad_reg.sv
// one pad configuration register with soft reset return to default
`timescale 1ns/1ps
`include "pcsr_cfg.svh"
module pcsr_pad_reg #(
  parameter logic [15:0] RESET_VAL = 16'h0018
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic soft_rst_active,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic pulldown_en,
  output logic [1:0] slew_code,
  output logic [1:0] drive_code
);
  if (RESET_VAL[15:5] != 11'h000) begin : g_bad_reset
    $error("reserved bits of the reset value must be zero");
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pulldown_en <= RESET_VAL[`PCSR_PULL_BIT];
      slew_code <= RESET_VAL[`PCSR_SLEW_HI:`PCSR_SLEW_LO];
      drive_code <= RESET_VAL[`PCSR_DRIVE_HI:`PCSR_DRIVE_LO];
    end else if (soft_rst_active) begin
      pulldown_en <= RESET_VAL[`PCSR_PULL_BIT];
      slew_code <= RESET_VAL[`PCSR_SLEW_HI:`PCSR_SLEW_LO];
      drive_code <= RESET_VAL[`PCSR_DRIVE_HI:`PCSR_DRIVE_LO];
    end else if (wr_en) begin
      pulldown_en <= wr_data[`PCSR_PULL_BIT];
      slew_code <= wr_data[`PCSR_SLEW_HI:`PCSR_SLEW_LO];
      drive_code <= wr_data[`PCSR_DRIVE_HI:`PCSR_DRIVE_LO];
    end
  end
endmodule : pcsr_pad_reg

// >>> logic/pcsr_regs.sv
// pad configuration and soft reset register bank
`timescale 1ns/1ps
`include "pcsr_cfg.svh"
// Operation
// RQ1: each pad register holds pull-down enable in bit 4, slew code in [3:2], drive code in [1:0], rest reserved.
// RQ2: pad a register resets to 0x0018.
// RQ3: pad b register has the same layout and resets to 0x0018.
// RQ4: clock output pad register has the same layout and resets to 0x0008.
// RQ5: soft reset control bit 0 is active low, 0 enters soft reset and 1 gives normal operation.
// RQ6: soft reset register resets to 0x0001 with bits [15:1] reserved.
// RQ7: while soft reset is active every control register returns to its default except the exempt ones.
// RQ8: the synthesizer registers 0xf000 to 0xf006 are untouched by soft reset.
// RQ9: panic manager registers keep their value through soft reset.
// RQ10: the slave control ports keep working during soft reset.
// RQ11: writes to the synthesizer registers are accepted and take effect during soft reset.
// RQ12: a slave port switched to spi mode stays in spi mode during and after soft reset.
// RQ13: only a hardware reset returns the slave port to i2c mode.
// RQ14: reserved bits ignore writes and read as zero.
module pcsr_regs (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire pcsr_pkg::pcsr_addr_t reg_addr,
  input wire pcsr_pkg::pcsr_word_t reg_wdata,
  input wire logic spi_mode_set,
  output pcsr_pkg::pcsr_word_t reg_rdata,
  output logic reg_rvalid,
  output logic pad_a_pulldown_en,
  output logic [1:0] pad_a_slew_code,
  output logic [1:0] pad_a_drive_code,
  output logic pad_b_pulldown_en,
  output logic [1:0] pad_b_slew_code,
  output logic [1:0] pad_b_drive_code,
  output logic clk_pad_pulldown_en,
  output logic [1:0] clk_pad_slew_code,
  output logic [1:0] clk_pad_drive_code,
  output logic soft_rst_active,
  output logic spi_mode,
  output logic synth_wr
);
  import pcsr_pkg::*;

  logic soft_reg;
  logic wr_pad_a;
  logic wr_pad_b;
  logic wr_clk_pad;
  logic wr_soft;
  logic hit_synth;
  pcsr_word_t rd_next;

  assign wr_pad_a = reg_wr && reg_addr == `PCSR_ADDR_PAD_A;
  assign wr_pad_b = reg_wr && reg_addr == `PCSR_ADDR_PAD_B;
  assign wr_clk_pad = reg_wr && reg_addr == `PCSR_ADDR_CLK_PAD;
  assign wr_soft = reg_wr && reg_addr == `PCSR_ADDR_SOFT_RST;
  assign hit_synth = reg_addr >= `PCSR_ADDR_SYNTH_LO && reg_addr <= `PCSR_ADDR_SYNTH_HI;

  // soft reset bit itself stays writable so software can leave the state
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      soft_reg <= `PCSR_RST_SOFT_BIT;
    end else if (wr_soft) begin
      soft_reg <= reg_wdata[0]; // RQ5
    end
  end

  // synth and panic registers live outside and must not consume this level,
  // so they keep their values through soft reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      soft_rst_active <= 1'b0; // RQ6
    end else begin
      soft_rst_active <= wr_soft ? ~reg_wdata[0] : ~soft_reg; // RQ5 RQ9
    end
  end

  // spi mode cleared only by the hardware reset pin
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      spi_mode <= 1'b0; // RQ13
    end else if (spi_mode_set) begin
      spi_mode <= 1'b1; // RQ12
    end
  end

  // synthesizer writes forwarded regardless of soft reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      synth_wr <= 1'b0;
    end else begin
      synth_wr <= reg_wr && hit_synth; // RQ8 RQ11
    end
  end

  pcsr_pad_reg #(.RESET_VAL(`PCSR_RST_PAD_A)) u_pad_a ( // RQ2
    .ref_clk(ref_clk),
    .nrst(nrst),
    .soft_rst_active(soft_rst_active), // RQ7
    .wr_en(wr_pad_a), // RQ1
    .wr_data(reg_wdata),
    .pulldown_en(pad_a_pulldown_en),
    .slew_code(pad_a_slew_code),
    .drive_code(pad_a_drive_code)
  );

  pcsr_pad_reg #(.RESET_VAL(`PCSR_RST_PAD_B)) u_pad_b ( // RQ3
    .ref_clk(ref_clk),
    .nrst(nrst),
    .soft_rst_active(soft_rst_active),
    .wr_en(wr_pad_b),
    .wr_data(reg_wdata),
    .pulldown_en(pad_b_pulldown_en),
    .slew_code(pad_b_slew_code),
    .drive_code(pad_b_drive_code)
  );

  pcsr_pad_reg #(.RESET_VAL(`PCSR_RST_CLK_PAD)) u_clk_pad ( // RQ4
    .ref_clk(ref_clk),
    .nrst(nrst),
    .soft_rst_active(soft_rst_active),
    .wr_en(wr_clk_pad),
    .wr_data(reg_wdata),
    .pulldown_en(clk_pad_pulldown_en),
    .slew_code(clk_pad_slew_code),
    .drive_code(clk_pad_drive_code)
  );

  // read path stays live during soft reset
  always_comb begin
    rd_next = 16'h0000;
    case (reg_addr)
      `PCSR_ADDR_PAD_A: rd_next = {11'h000, pad_a_pulldown_en, pad_a_slew_code, pad_a_drive_code}; // RQ14
      `PCSR_ADDR_PAD_B: rd_next = {11'h000, pad_b_pulldown_en, pad_b_slew_code, pad_b_drive_code};
      `PCSR_ADDR_CLK_PAD: rd_next = {11'h000, clk_pad_pulldown_en, clk_pad_slew_code, clk_pad_drive_code};
      `PCSR_ADDR_SOFT_RST: rd_next = {15'h0000, soft_reg}; // RQ14
      default: rd_next = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd; // RQ10
      if (reg_rd) begin
        reg_rdata <= rd_next;
      end
    end
  end

  chk_soft_pad_default: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ7
    soft_rst_active |=> pad_a_pulldown_en && pad_a_slew_code == 2'h2 && pad_a_drive_code == 2'h0)
    else $error("pad a not at default during soft reset");
  chk_clk_pad_default: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ4
    soft_rst_active |=> !clk_pad_pulldown_en && clk_pad_slew_code == 2'h2 && clk_pad_drive_code == 2'h0)
    else $error("clock pad not at default during soft reset");
  chk_soft_enter: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ5
    wr_soft && !reg_wdata[0] |=> soft_rst_active)
    else $error("soft reset not entered");
  chk_soft_leave: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ5
    wr_soft && reg_wdata[0] |=> !soft_rst_active)
    else $error("soft reset not left");
  chk_pad_write: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ1
    wr_pad_b && !soft_rst_active |=> pad_b_slew_code == $past(reg_wdata[3:2]) && pad_b_drive_code == $past(reg_wdata[1:0]))
    else $error("pad b write lost");
  chk_spi_sticky: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ12
    spi_mode |=> spi_mode)
    else $error("spi mode dropped");
  chk_synth_live: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ11
    reg_wr && hit_synth |=> synth_wr)
    else $error("synth write blocked");
  chk_read_live: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ10
    reg_rd |=> reg_rvalid)
    else $error("read not answered");
  chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ14
    reg_rvalid |-> reg_rdata[15:5] == 11'h000)
    else $error("reserved bits not zero");

  // field checks
  chk_pad_a_write: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ1
    wr_pad_a && !soft_rst_active |=> pad_a_pulldown_en == $past(reg_wdata[4])
      && pad_a_slew_code == $past(reg_wdata[3:2]) && pad_a_drive_code == $past(reg_wdata[1:0]))
    else $error("pad a write lost");
  chk_clk_pad_write: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ1
    wr_clk_pad && !soft_rst_active |=> clk_pad_pulldown_en == $past(reg_wdata[4])
      && clk_pad_slew_code == $past(reg_wdata[3:2]) && clk_pad_drive_code == $past(reg_wdata[1:0]))
    else $error("clock pad write lost");
  chk_pad_a_held: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ1
    !wr_pad_a && !soft_rst_active |=> $stable(pad_a_pulldown_en) && $stable(pad_a_slew_code)
      && $stable(pad_a_drive_code))
    else $error("pad a changed without a write");
  chk_clk_pad_held: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ4
    !wr_clk_pad && !soft_rst_active |=> $stable(clk_pad_pulldown_en) && $stable(clk_pad_slew_code)
      && $stable(clk_pad_drive_code))
    else $error("clock pad changed without a write");

  // soft reset state checks
  chk_pad_b_default: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ7
    soft_rst_active |=> pad_b_pulldown_en && pad_b_slew_code == 2'h2 && pad_b_drive_code == 2'h0)
    else $error("pad b not at default during soft reset");
  chk_soft_persist: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ7
    soft_rst_active && !wr_soft |=> soft_rst_active)
    else $error("soft reset cleared itself");
  chk_normal_persist: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ5
    !soft_rst_active && !wr_soft |=> !soft_rst_active)
    else $error("soft reset entered without a write");
  chk_soft_read: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ6
    reg_rd && !reg_wr && reg_addr == `PCSR_ADDR_SOFT_RST |=> reg_rdata == {15'h0000, ~soft_rst_active})
    else $error("soft reset readback wrong");

  // bus answer, synth strobe and spi mode checks
  chk_rdata_hold: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ10
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  chk_rvalid_pulse: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ10
    !reg_rd |=> !reg_rvalid)
    else $error("read valid without a read");
  chk_synth_only: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ8
    !(reg_wr && hit_synth) |=> !synth_wr)
    else $error("synth write outside its range");
  chk_spi_latch: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ12
    spi_mode_set |=> spi_mode)
    else $error("spi mode not latched");
endmodule : pcsr_regs

// >>> verification/tb_pcsr_regs.sv
// self-checking bench for the pad config and soft reset bank
`timescale 1ns/1ps
module tb_pcsr_regs;
  import pcsr_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic spi_mode_set = 1'b0;
  pcsr_addr_t reg_addr = 16'h0000;
  pcsr_word_t reg_wdata = 16'h0000;
  pcsr_word_t reg_rdata;
  logic reg_rvalid, soft_rst_active, spi_mode, synth_wr;
  wire [4:0] pa, pb, pc;
  int num_errors = 0;
  int n_checks = 0;
  initial forever #2 ref_clk = ~ref_clk;
  pcsr_regs dut_u (.ref_clk(ref_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .spi_mode_set(spi_mode_set), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pad_a_pulldown_en(pa[4]), .pad_a_slew_code(pa[3:2]), .pad_a_drive_code(pa[1:0]),
    .pad_b_pulldown_en(pb[4]), .pad_b_slew_code(pb[3:2]), .pad_b_drive_code(pb[1:0]),
    .clk_pad_pulldown_en(pc[4]), .clk_pad_slew_code(pc[3:2]), .clk_pad_drive_code(pc[1:0]),
    .soft_rst_active(soft_rst_active), .spi_mode(spi_mode), .synth_wr(synth_wr));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // every request starts on an edge so strobes never collide
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk({15'h0000, reg_rvalid}, 16'h0001);
    chk(reg_rdata, exp);
  endtask : rd
  task automatic t_reset;
    rd(16'hf7a1, 16'h0018);
    rd(16'hf7a2, 16'h0018);
    rd(16'hf7a3, 16'h0008);
    rd(16'hf890, 16'h0001);
    chk({1'b0, pa, pb, pc}, {1'b0, 5'h18, 5'h18, 5'h08});
    $display("test reset done");
  endtask : t_reset
  task automatic t_fields;
    for (int i = 0; i < 4; i++) begin
      wr(16'hf7a2, {11'h000, i[0], i[1:0], 2'(3 - i)});
      chk({11'h000, pb}, {11'h000, i[0], i[1:0], 2'(3 - i)});
    end
    wr(16'hf7a1, 16'hffff);
    rd(16'hf7a1, 16'h001f);
    wr(16'hf7a3, 16'hfff2);
    chk({11'h000, pc}, 16'h0012);
    wr(16'hf890, 16'hffff);
    rd(16'hf890, 16'h0001);
    rd(16'h1234, 16'h0000);
    $display("test fields done");
  endtask : t_fields
  task automatic t_soft;
    wr(16'hf890, 16'h0000);
    chk({15'h0000, soft_rst_active}, 16'h0001);
    @(posedge ref_clk);
    #1;
    chk({1'b0, pa, pb, pc}, {1'b0, 5'h18, 5'h18, 5'h08});
    wr(16'hf7a1, 16'h0000);
    rd(16'hf7a1, 16'h0018);
    wr(16'hf006, 16'h1234);
    chk({15'h0000, synth_wr}, 16'h0001);
    wr(16'hf007, 16'h1234);
    chk({15'h0000, synth_wr}, 16'h0000);
    rd(16'hf890, 16'h0000);
    @(posedge ref_clk);
    spi_mode_set <= 1'b1;
    @(posedge ref_clk);
    spi_mode_set <= 1'b0;
    #1;
    chk({15'h0000, spi_mode}, 16'h0001);
    wr(16'hf890, 16'h0001);
    @(posedge ref_clk);
    #1;
    chk({14'h0000, soft_rst_active, spi_mode}, 16'h0001);
    wr(16'hf7a1, 16'h0000);
    chk({11'h000, pa}, 16'h0000);
    $display("test soft reset done");
  endtask : t_soft
  // only the reset pin brings the slave port back out of spi mode
  task automatic t_hw_reset;
    wr(16'hf890, 16'h0000);
    @(posedge ref_clk);
    nrst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk({14'h0000, soft_rst_active, spi_mode}, 16'h0000);
    chk({1'b0, pa, pb, pc}, {1'b0, 5'h18, 5'h18, 5'h08});
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(16'hf890, 16'h0001);
    wr(16'hf7a2, 16'h0005);
    rd(16'hf7a2, 16'h0005);
    $display("test hardware reset done");
  endtask : t_hw_reset
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  // whole run is under a hundred cycles, so 20 us is ample
  initial begin
    #20000;
    num_errors++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_fields();
    t_soft();
    t_hw_reset();
    test_done();
  end
endmodule : tb_pcsr_regs
